// *** rtl/instruction_word_decode_timing.sv ***
// Instruction word decode and execution cycle timing with an APB control slave.
`timescale 1ns/1ps
`include "iwd_defs.svh"
module instruction_word_decode_timing (
    // Clock and reset.
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    // APB slave.
    input  wire logic [11:0]         paddr_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [31:0]         pwdata_i,
    output logic [31:0]              prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // Program memory words.
    input  wire logic                word_valid_i,
    input  wire logic [23:0]         word_i,
    output logic                     word_ready_o,
    // Execute unit side.
    input  wire iwd_pkg::exec_attr_t exec_attr_i,
    input  wire iwd_pkg::flag_upd_t  flag_upd_i,
    // Decode and timing results.
    output logic                     issue_valid_o,
    output iwd_pkg::fields_t         fields_o,
    output logic                     nop_cycle_o,
    output logic                     retire_o,
    output logic [1:0]               instr_cycles_o,
    output logic                     operand_error_o,
    output iwd_pkg::flags_t          flags_o
);
    import iwd_pkg::*;

    state_t      state_q;
    state_t      state_d;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic [23:0] first_q;
    logic [23:0] first_d;
    logic        done;
    logic        nop_d;
    logic        exec_d;
    logic [1:0]  ctrl_q;
    logic        err_acc_q;
    logic        exec_q;
    logic        nop_q;
    logic        retire_q;
    logic [1:0]  cycles_q;
    logic        oper_err_q;
    logic [31:0] prdata_q;
    fields_t     fields_q;
    fields_t     dec;
    flags_t      flags;

    // Control bits and fetch handshake.
    wire ctrl_en = ctrl_q[`CTRL_EN_BIT];
    wire chk_en  = ctrl_q[`CTRL_CHK_BIT];
    assign word_ready_o = ctrl_en && (state_q != ST_NOP);
    wire accept = word_valid_i && word_ready_o;

    // The extractor sees the held first word while its extension arrives.
    wire in_ext_state   = (state_q == ST_EXT);
    wire [23:0] dec_hi  = in_ext_state ? first_q : word_i;
    wire [23:0] dec_lo  = in_ext_state ? word_i : 24'h000000;

    operand_field_decode u_fields (
        .first_word_i (dec_hi),
        .ext_word_i   (dec_lo),
        .fields_o     (dec)
    );

    // Reasons for an inserted cycle on a single-word instruction.
    wire movd  = (dec.opcode == `OPC_MOVE) && (dec.width == W_DOUBLE);
    wire extra = exec_attr_i.cond_true || exec_attr_i.pc_change ||
                 exec_attr_i.program_space_view || exec_attr_i.table_read ||
                 exec_attr_i.sfr_read || movd;

    // Operand encoding checks.
    wire ext_bad   = in_ext_state && (word_i[`F_OPC] != `EXT_MARK);
    wire wide_unsigned_literal_bad = in_ext_state && dec.wide_unsigned_literal[0];
    wire mid_unsigned_literal_bad = (dec.width == W_BYTE) && (dec.mid_unsigned_literal > `MID_UNSIGNED_LITERAL_BYTE_MAX);
    wire mode_bad  = (dec.dest_mode == DM_RSVD);
    wire width_bad = (dec.width == W_RSVD);
    wire err_now   = chk_en && exec_d && (ext_bad || wide_unsigned_literal_bad || mid_unsigned_literal_bad || mode_bad || width_bad);
    wire err_acc_d = ((state_q == ST_FETCH) ? 1'b0 : err_acc_q) || err_now;

    // Sequencing of words and cycles.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        first_d = first_q;
        done    = 1'b0;
        nop_d   = 1'b0;
        exec_d  = 1'b0;
        unique case (state_q)
            ST_FETCH: begin
                if (accept) begin
                    cnt_d = `CYC_ONE;
                    if (dec.extension_word) begin
                        nop_d = 1'b1;
                        done  = 1'b1;
                    end else if (dec.double_word) begin
                        first_d = word_i;
                        state_d = ST_EXT;
                    end else begin
                        exec_d = 1'b1;
                        if (exec_attr_i.skip_taken) begin
                            state_d = ST_SKIP;
                        end else if (extra) begin
                            state_d = ST_NOP;
                        end else begin
                            done = 1'b1;
                        end
                    end
                end
            end
            ST_EXT: begin
                if (accept) begin
                    cnt_d   = cnt_q + `CYC_ONE;
                    exec_d  = 1'b1;
                    done    = 1'b1;
                    state_d = ST_FETCH;
                end
            end
            ST_NOP: begin
                cnt_d   = cnt_q + `CYC_ONE;
                nop_d   = 1'b1;
                done    = 1'b1;
                state_d = ST_FETCH;
            end
            ST_SKIP: begin
                if (accept) begin
                    cnt_d = cnt_q + `CYC_ONE;
                    nop_d = 1'b1;
                    if (dec.double_word) begin
                        state_d = ST_SKIP_EXT;
                    end else begin
                        done    = 1'b1;
                        state_d = ST_FETCH;
                    end
                end
            end
            ST_SKIP_EXT: begin
                if (accept) begin
                    cnt_d   = cnt_q + `CYC_ONE;
                    nop_d   = 1'b1;
                    done    = 1'b1;
                    state_d = ST_FETCH;
                end
            end
            default: begin
                state_d = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q   <= ST_FETCH;
            cnt_q     <= 2'h0;
            first_q   <= 24'h000000;
            err_acc_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            first_q   <= first_d;
            err_acc_q <= err_acc_d;
        end
    end

    // Registered results; fields only move on an executing cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fields_q   <= '0;
            exec_q     <= 1'b0;
            nop_q      <= 1'b0;
            retire_q   <= 1'b0;
            cycles_q   <= 2'h0;
            oper_err_q <= 1'b0;
        end else begin
            fields_q   <= exec_d ? dec : fields_q;
            exec_q     <= exec_d;
            nop_q      <= nop_d;
            retire_q   <= done;
            cycles_q   <= done ? cnt_d : cycles_q;
            oper_err_q <= done && err_acc_d;
        end
    end

    assign issue_valid_o   = exec_q;
    assign fields_o        = fields_q;
    assign nop_cycle_o     = nop_q;
    assign retire_o        = retire_q;
    assign instr_cycles_o  = cycles_q;
    assign operand_error_o = oper_err_q;

    // Flags change only on executing cycles, never on inserted ones.
    status_flags u_flags (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .upd_en_i  (exec_d),
        .upd_i     (flag_upd_i),
        .flags_o   (flags)
    );
    assign flags_o = flags;

    // APB decode.
    wire sel_ctrl  = (paddr_i == `REG_CTRL);
    wire sel_flags = (paddr_i == `REG_FLAGS);
    wire sel_last  = (paddr_i == `REG_LAST);
    wire mapped    = sel_ctrl || sel_flags || sel_last;
    wire setup     = psel_i && !penable_i;
    wire access    = psel_i && penable_i;
    wire ctrl_wr   = access && pwrite_i && sel_ctrl;
    wire [31:0] rd_mux = sel_ctrl  ? {30'h00000000, ctrl_q} :
                         sel_flags ? {23'h000000, flags} :
                         sel_last  ? {26'h0000000, oper_err_q, state_q, cycles_q} :
                                     32'h00000000;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q   <= `CTRL_RST;
            prdata_q <= 32'h00000000;
        end else begin
            ctrl_q   <= ctrl_wr ? pwdata_i[1:0] : ctrl_q;
            prdata_q <= setup ? rd_mux : prdata_q;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = 1'b1;
    assign pslverr_o = access && !mapped;

    // Checks.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    wire fetch_acc = (state_q == ST_FETCH) && accept;
    wire plain_one = fetch_acc && !dec.extension_word && !dec.double_word && !exec_attr_i.skip_taken && !extra;

    a_ext_upper_zero: assert property (ext_bad && chk_en && accept |=> operand_error_o)
        else $error("nonzero extension word upper byte not flagged");
    a_stray_ext_nop: assert property (fetch_acc && dec.extension_word |=>
        nop_cycle_o && retire_o && instr_cycles_o == 2'h1 && !issue_valid_o)
        else $error("stray extension word not a single nop cycle");
    a_double_two_cycles: assert property (in_ext_state && accept |=> retire_o && instr_cycles_o == 2'h2)
        else $error("double-word instruction not two cycles");
    a_single_one_cycle: assert property (plain_one |=> retire_o && instr_cycles_o == 2'h1)
        else $error("plain single-word instruction not one cycle");
    a_extra_nop_cycle: assert property (fetch_acc && exec_d && extra && !exec_attr_i.skip_taken |=>
        !word_ready_o ##1 nop_cycle_o && retire_o && instr_cycles_o == 2'h2)
        else $error("inserted cycle not a nop");
    a_skip_single: assert property ((state_q == ST_SKIP) && accept && !dec.double_word |=>
        retire_o && instr_cycles_o == 2'h2)
        else $error("skip over single word not two cycles");
    a_skip_double: assert property ((state_q == ST_SKIP_EXT) && accept |=> retire_o && instr_cycles_o == 2'h3)
        else $error("skip over double word not three cycles");
    a_move_double: assert property (fetch_acc && movd && !dec.double_word && !dec.extension_word &&
        !exec_attr_i.skip_taken |-> ##2 retire_o && instr_cycles_o == 2'h2)
        else $error("double-word move not two cycles");
    a_wide_unsigned_literal_lsb: assert property (chk_en && in_ext_state && accept && dec.wide_unsigned_literal[0] |=>
        operand_error_o)
        else $error("odd wide literal not flagged");
    a_mid_unsigned_literal_byte: assert property (chk_en && plain_one && mid_unsigned_literal_bad |=> operand_error_o)
        else $error("byte literal above 255 not flagged");
    a_nop_flags_hold: assert property (nop_d |=> $stable(flags_o) && $stable(fields_o))
        else $error("state changed on a nop cycle");

    c_double_word: cover property (in_ext_state && accept ##1 retire_o);
    c_skip_double: cover property ((state_q == ST_SKIP_EXT) && accept);
    c_stray_ext: cover property (fetch_acc && dec.extension_word);
    c_extra_cycle: cover property ((state_q == ST_NOP) ##1 retire_o);

endmodule

// *** shared/iwd_defs.svh ***
// Offsets, field positions, reset values and cycle counts of the instruction decoder.
`ifndef IWD_DEFS_SVH
`define IWD_DEFS_SVH

`define REG_CTRL        12'h000
`define REG_FLAGS       12'h004
`define REG_LAST        12'h008

`define CTRL_RST        2'h1
`define CTRL_EN_BIT     0
`define CTRL_CHK_BIT    1
`define FLAGS_RST       9'h000

`define F_OPC           23:16
`define F_WIDTH         15:14
`define F_ACC           15
`define F_AWB           14
`define F_BITSEL        15:12
`define F_MID_UNSIGNED_LITERAL         13:4
`define F_FILE          12:0
`define F_BASE          10:7
`define F_DMODE         6:4
`define F_DREG          3:0
`define F_EXT_LIT       6:0

`define EXT_MARK        8'h00
`define OPC_DW_CALL     8'h02
`define OPC_DW_JUMP     8'h04
`define OPC_DW_LOOP     8'h08
`define OPC_MOVE        8'hbe
`define MID_UNSIGNED_LITERAL_BYTE_MAX  10'h0ff

`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

`endif

// *** shared/iwd_pkg.sv ***
// Types shared by the instruction decoder, its field extractor and its status flags.
package iwd_pkg;

    typedef enum logic [1:0] {
        W_WORD   = 2'b00,
        W_BYTE   = 2'b01,
        W_DOUBLE = 2'b10,
        W_RSVD   = 2'b11
    } width_t;

    typedef enum logic [2:0] {
        DM_DIRECT   = 3'b000,
        DM_IND      = 3'b001,
        DM_POSTDEC  = 3'b010,
        DM_POSTINC  = 3'b011,
        DM_PREDEC   = 3'b100,
        DM_PREINC   = 3'b101,
        DM_BASE_OFS = 3'b110,
        DM_RSVD     = 3'b111
    } dest_mode_t;

    typedef enum logic {ACC_A = 1'b0, ACC_B = 1'b1} acc_sel_t;

    typedef enum logic {WB_REG = 1'b0, WB_IND_POSTINC = 1'b1} wb_target_t;

    typedef enum logic [2:0] {
        ST_FETCH    = 3'b000,
        ST_EXT      = 3'b001,
        ST_NOP      = 3'b010,
        ST_SKIP     = 3'b011,
        ST_SKIP_EXT = 3'b100
    } state_t;

    typedef struct packed {
        logic [7:0]  opcode;
        width_t      width;
        logic [12:0] file_addr;
        logic [3:0]  bit_position_selector;
        logic [9:0]  mid_unsigned_literal;
        logic [15:0] mid_signed_literal;
        acc_sel_t    acc;
        wb_target_t  write_back_target;
        logic [3:0]  base_working_register;
        logic [3:0]  dest_reg;
        dest_mode_t  dest_mode;
        logic [22:0] wide_unsigned_literal;
        logic        double_word;
        logic        extension_word;
    } fields_t;

    typedef struct packed {
        logic cond_true;
        logic pc_change;
        logic program_space_view;
        logic table_read;
        logic sfr_read;
        logic skip_taken;
    } exec_attr_t;

    typedef struct packed {
        logic mcu_we;
        logic carry;
        logic digit_carry;
        logic negative;
        logic overflow;
        logic zero;
        logic zero_sticky;
        logic acc_a_we;
        logic oa;
        logic sa;
        logic acc_b_we;
        logic ob;
        logic sb;
    } flag_upd_t;

    typedef struct packed {
        logic sb;
        logic sa;
        logic ob;
        logic oa;
        logic zero;
        logic overflow;
        logic negative;
        logic digit_carry;
        logic carry;
    } flags_t;

endpackage

// *** rtl/operand_field_decode.sv ***
// Combinational operand field extraction for one instruction word and its extension word.
`timescale 1ns/1ps
`include "iwd_defs.svh"
module operand_field_decode (
    // Instruction words.
    input  wire logic [23:0]  first_word_i,
    input  wire logic [23:0]  ext_word_i,
    // Decoded fields.
    output iwd_pkg::fields_t  fields_o
);
    import iwd_pkg::*;

    wire [7:0] opc = first_word_i[`F_OPC];

    assign fields_o.opcode                = opc;
    assign fields_o.width                 = width_t'(first_word_i[`F_WIDTH]);
    assign fields_o.file_addr             = first_word_i[`F_FILE];
    assign fields_o.bit_position_selector = first_word_i[`F_BITSEL];
    assign fields_o.mid_unsigned_literal  = first_word_i[`F_MID_UNSIGNED_LITERAL];
    assign fields_o.mid_signed_literal    = {{6{first_word_i[13]}}, first_word_i[`F_MID_UNSIGNED_LITERAL]};
    assign fields_o.acc                   = acc_sel_t'(first_word_i[`F_ACC]);
    assign fields_o.write_back_target     = wb_target_t'(first_word_i[`F_AWB]);
    assign fields_o.base_working_register = first_word_i[`F_BASE];
    assign fields_o.dest_reg              = first_word_i[`F_DREG];
    assign fields_o.dest_mode             = dest_mode_t'(first_word_i[`F_DMODE]);
    assign fields_o.wide_unsigned_literal = {ext_word_i[`F_EXT_LIT], first_word_i[15:0]};
    assign fields_o.double_word           = (opc == `OPC_DW_CALL) || (opc == `OPC_DW_JUMP) ||
                                            (opc == `OPC_DW_LOOP);
    assign fields_o.extension_word        = (opc == `EXT_MARK);

endmodule

// *** rtl/status_flags.sv ***
// General and accumulator status flags updated by executing instructions.
`timescale 1ns/1ps
`include "iwd_defs.svh"
module status_flags (
    // Clock and reset.
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // Update request.
    input  wire logic              upd_en_i,
    input  wire iwd_pkg::flag_upd_t upd_i,
    // Flag state.
    output iwd_pkg::flags_t        flags_o
);
    import iwd_pkg::*;

    flags_t flags_q;
    flags_t flags_d;

    wire mcu_go = upd_en_i && upd_i.mcu_we;
    wire a_go   = upd_en_i && upd_i.acc_a_we;
    wire b_go   = upd_en_i && upd_i.acc_b_we;

    always_comb begin
        flags_d = flags_q;
        if (mcu_go) begin
            flags_d.carry       = upd_i.carry;
            flags_d.digit_carry = upd_i.digit_carry;
            flags_d.negative    = upd_i.negative;
            flags_d.overflow    = upd_i.overflow;
            flags_d.zero        = upd_i.zero_sticky ? (flags_q.zero & upd_i.zero) : upd_i.zero;
        end
        if (a_go) begin
            flags_d.oa = upd_i.oa;
            flags_d.sa = upd_i.sa;
        end
        if (b_go) begin
            flags_d.ob = upd_i.ob;
            flags_d.sb = upd_i.sb;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flags_q <= `FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule

// *** tb/prog_mem_model.sv ***
// Program memory model that offers queued instruction words with random wait cycles.
`timescale 1ns/1ps
module prog_mem_model (
    // Clock.
    input  wire logic           ref_clk_i,
    // Fetch handshake.
    input  wire logic           word_ready_i,
    output logic                word_valid_o,
    output logic [23:0]         word_o,
    // Attributes travelling with each word.
    output iwd_pkg::exec_attr_t attr_o,
    output iwd_pkg::flag_upd_t  upd_o
);
    import iwd_pkg::*;
    logic [42:0] q[$];
    initial begin
        word_valid_o = 1'b0;
        {attr_o, upd_o, word_o} = 43'h0;
    end
    // An idle bus shows the inverse of its last value, so nothing is taken from it by luck.
    always @(posedge ref_clk_i) begin
        if (word_valid_o && word_ready_i) begin
            void'(q.pop_front());
        end
        if (!(word_valid_o && !word_ready_i)) begin
            if (q.size() > 0 && $urandom_range(3) != 0) begin
                word_valid_o <= 1'b1;
                {attr_o, upd_o, word_o} <= q[0];
            end else begin
                word_valid_o <= 1'b0;
                {attr_o, upd_o, word_o} <= ~{attr_o, upd_o, word_o};
            end
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the instruction word decoder and its cycle timing.
`timescale 1ns/1ps
`include "iwd_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
$display("ERROR at %0t: got %0h, expected %0h", $time, (a), (b)); end end
module tb;
    import iwd_pkg::*;
    logic        ref_clk, rst, psel, penable, pwrite, word_valid, word_ready, pready, pslverr;
    logic        issue_valid, nop_cycle, retire, op_err, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] word;
    logic [1:0]  cycles;
    logic [2:0]  xv;
    logic [48:0] v;
    logic [15:0] nc, nexp = 16'h0;
    exec_attr_t  attr;
    flag_upd_t   upd;
    fields_t     f;
    flags_t      flags, ef = 9'h0;
    logic [2:0]  xq[$];
    logic [48:0] fq[$];
    logic [7:0]  dw_opc[3] = '{`OPC_DW_CALL, `OPC_DW_JUMP, `OPC_DW_LOOP};
    logic [15:0] chk_lo[5] = '{16'h5000, 16'h4f80, 16'h3f80, 16'hc000, 16'h0070};
    logic        chk_err[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    int          error_cnt = 0, comparisons = 0;

    instruction_word_decode_timing instruction_word_decode_timing_inst (
        .ref_clk_i(ref_clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .word_valid_i(word_valid), .word_i(word), .word_ready_o(word_ready), .exec_attr_i(attr),
        .flag_upd_i(upd), .issue_valid_o(issue_valid), .fields_o(f), .nop_cycle_o(nop_cycle),
        .retire_o(retire), .instr_cycles_o(cycles), .operand_error_o(op_err), .flags_o(flags));
    prog_mem_model prog_mem_model_inst (
        .ref_clk_i(ref_clk), .word_ready_i(word_ready), .word_valid_o(word_valid), .word_o(word),
        .attr_o(attr), .upd_o(upd));

    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task bail;
        error_cnt++;
        report_and_stop;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n == 64) bail;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task ins(input logic [23:0] w, input exec_attr_t a, input logic ex, input logic [4:0] x);
        flag_upd_t u;
        u = 13'($urandom);
        prog_mem_model_inst.q.push_back({a, u, w});
        if (ex && u.mcu_we) begin
            {ef.carry, ef.digit_carry} = {u.carry, u.digit_carry};
            {ef.negative, ef.overflow} = {u.negative, u.overflow};
            ef.zero = u.zero_sticky ? ef.zero & u.zero : u.zero;
        end
        if (ex && u.acc_a_we) {ef.oa, ef.sa} = {u.oa, u.sa};
        if (ex && u.acc_b_we) {ef.ob, ef.sb} = {u.ob, u.sb};
        if (x[1:0] != 2'h0) xq.push_back(x[2:0]);
        nexp = nexp + {14'h0, x[4:3]};
    endtask
    task sgl(input logic [23:0] w, input exec_attr_t a, input logic [4:0] x);
        ins(w, a, 1'b1, x);
        fq.push_back({25'h0, w});
    endtask
    task dbl(input logic [23:0] w, input logic [23:0] w2, input logic [4:0] x);
        ins(w, 6'h0, 1'b0, 5'h0);
        ins(w2, 6'h0, 1'b1, x);
        fq.push_back({1'b1, w2, w});
    endtask
    function automatic logic [23:0] rw(input logic [15:0] lo);
        return {8'($urandom_range(16, 189)), lo};
    endfunction
    task drain(input int t);
        int n;
        n = 0;
        while ((prog_mem_model_inst.q.size() > 0 || xq.size() > 0) && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 3000) bail;
        repeat (4) @(posedge ref_clk);
        `CHK(nc, nexp)
        `CHK(flags, ef)
        apb(1'b0, `REG_FLAGS, 32'h0);
        `CHK(r, {23'h0, ef})
        $display("test %0d done", t);
    endtask

    always @(negedge ref_clk) begin
        if (rst) begin
            nc <= 16'h0;
        end else begin
            if (nop_cycle) nc <= nc + 16'h1;
            if (retire) begin
                xv = xq.pop_front();
                `CHK({op_err, cycles}, xv)
            end
            if (issue_valid) begin
                v = fq.pop_front();
                `CHK({f.opcode, f.width, f.file_addr}, {v[`F_OPC], v[`F_WIDTH], v[`F_FILE]})
                `CHK({f.bit_position_selector, f.mid_unsigned_literal}, {v[`F_BITSEL], v[`F_MID_UNSIGNED_LITERAL]})
                `CHK({f.acc, f.write_back_target, f.base_working_register}, {v[`F_ACC], v[`F_AWB], v[`F_BASE]})
                `CHK({f.dest_reg, f.dest_mode}, {v[`F_DREG], v[`F_DMODE]})
                `CHK(f.mid_signed_literal, {{6{v[13]}}, v[`F_MID_UNSIGNED_LITERAL]})
                if (v[48]) `CHK({f.double_word, f.wide_unsigned_literal}, {1'b1, v[30:24], v[15:0]})
            end
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
        void'($urandom(65476));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK({word_ready, flags, retire, issue_valid}, {1'b1, 9'h0, 2'h0})
        apb(1'b0, `REG_CTRL, 32'h0);
        `CHK({e, r}, {1'b0, 30'h0, `CTRL_RST})
        apb(1'b1, `REG_FLAGS, 32'h1ff);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({e, r}, 33'h100000000)
        apb(1'b1, `REG_CTRL, 32'h0);
        sgl(rw(16'h0), 6'h0, 5'h01);
        repeat (8) @(posedge ref_clk);
        `CHK(prog_mem_model_inst.q.size(), 1)
        apb(1'b1, `REG_CTRL, 32'h1);
        drain(1);
        repeat (20) sgl(rw(16'($urandom)), 6'h0, 5'h01);
        drain(2);
        for (int k = 1; k < 6; k++) sgl(rw(16'($urandom)), 6'(1 << k), 5'h0a);
        sgl({`OPC_MOVE, 2'b10, 14'($urandom)}, 6'h0, 5'h0a);
        ins({`EXT_MARK, 16'($urandom)}, 6'h0, 1'b0, 5'h09);
        drain(3);
        repeat (2) foreach (dw_opc[i]) dbl({dw_opc[i], 16'($urandom)}, {`EXT_MARK, 16'($urandom)}, 5'h02);
        drain(4);
        sgl(rw(16'($urandom)), 6'h3f, 5'h0a);
        ins(rw(16'($urandom)), 6'h0, 1'b0, 5'h0);
        sgl(rw(16'($urandom)), 6'h01, 5'h13);
        ins({`OPC_DW_JUMP, 16'($urandom)}, 6'h0, 1'b0, 5'h0);
        ins({`EXT_MARK, 16'($urandom)}, 6'h0, 1'b0, 5'h0);
        drain(5);
        apb(1'b1, `REG_CTRL, 32'h3);
        foreach (chk_lo[i]) sgl(rw(chk_lo[i]), 6'h0, {2'h0, chk_err[i], 2'h1});
        dbl({`OPC_DW_CALL, 16'h0001}, 24'h0, 5'h06);
        dbl({`OPC_DW_LOOP, 16'h0000}, 24'h010000, 5'h06);
        dbl({`OPC_DW_JUMP, 16'h0002}, 24'h000040, 5'h02);
        drain(6);
        report_and_stop;
    end
endmodule
